// ===== hw/cfgjt_ctrl.sv
`timescale 1ns/1ps
`include "cfgjt_defs.svh"

// Contract
// - Done status high only once configured.
// - Low reset pin clears configuration logic asynchronously.
// - Reset pin never touches test controller.
// - Serial input feeds register chosen by state.
// - Serial input captured on test clock rise.
// - Serial output from selected register.
// - Serial output changes on falling edges.
// - Serial output driven only while shifting.
// - Mode select steers controller each rise.
// - Undriven mode select reads as high.
// - Undriven serial input reads as high.
// - Suspend input enters suspend mode once configured.
// - Dedicated pins keep configuration role.

module cfgjt_ctrl #(
   parameter int IR_W = `CFGJT_IR_W,
   parameter int DR_W = `CFGJT_DR_W,
   // Arbitrary neutral identification value.
   parameter logic [31:0] ID_VALUE = 32'h0A5C_3E11,
   parameter int CFG_CYCLES = `CFGJT_CFG_CYCLES
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Reconfiguration reset pin, active low, asynchronous
   input wire logic prog_n,
   // Suspend pin
   input wire logic susp_pin,
   // Configuration-complete pin, open drain
   input wire logic done_i,
   output cfgjt_pkg::cfgjt_done_pin_t done_pin,
   // Status toward the system
   output logic cfg_done,
   output logic suspend_active,
   // Test access port
   input wire logic tck,
   input wire cfgjt_pkg::cfgjt_jtag_in_t jtag_in,
   output cfgjt_pkg::cfgjt_jtag_out_t jtag_out
);

   localparam int CW = $clog2(CFG_CYCLES + 1);
   localparam logic [CW-1:0] CNT_END = CW'(CFG_CYCLES);

   generate
      if (IR_W < 2 || DR_W < 2 || DR_W > 32 || CFG_CYCLES < 1) begin : g_chk
         $error("cfgjt_ctrl: unsupported parameter values");
      end
   endgenerate

   // ****************************************************************
   // Configuration sequence on the system clock
   // ****************************************************************
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic done_oe_reg;
   logic done_s1_reg;
   logic done_s2_reg;
   logic cfg_done_reg;
   logic susp_s1_reg;
   logic susp_s2_reg;
   logic susp_reg;
   logic prog_s1_reg;
   logic prog_s2_reg;
   wire cnt_at_end = (cnt_reg == CNT_END);

   assign cnt_next = cnt_at_end ? cnt_reg : cnt_reg + CW'(1);

   // The pin clears at once, but its release is retimed by two flops so
   // that no register leaves reset on a marginal edge.
   always_ff @(posedge clk_sys or negedge prog_n) begin
      if (!prog_n) begin
         prog_s1_reg <= 1'b0;
         prog_s2_reg <= 1'b0;
      end else begin
         prog_s1_reg <= 1'b1;
         prog_s2_reg <= prog_s1_reg;
      end
   end

   wire cfg_hold = rst || !prog_s2_reg;

   // The pin clears everything here without waiting for a clock edge.
   always_ff @(posedge clk_sys or negedge prog_n) begin
      if (!prog_n) begin
         cnt_reg <= '0;
         done_oe_reg <= 1'b1;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         cfg_done_reg <= 1'b0;
         susp_s1_reg <= 1'b0;
         susp_s2_reg <= 1'b0;
         susp_reg <= 1'b0;
      end else if (cfg_hold) begin
         cnt_reg <= '0;
         done_oe_reg <= 1'b1;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         cfg_done_reg <= 1'b0;
         susp_s1_reg <= 1'b0;
         susp_s2_reg <= 1'b0;
         susp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done_oe_reg <= (cnt_next != CNT_END);
         done_s1_reg <= done_i;
         done_s2_reg <= done_s1_reg;
         cfg_done_reg <= cnt_at_end && done_s2_reg;
         susp_s1_reg <= susp_pin;
         susp_s2_reg <= susp_s1_reg;
         susp_reg <= susp_s2_reg && cfg_done_reg;
      end
   end

   // The pin stays the done indicator for good; no user path reaches it.
   assign done_pin.o = 1'b0;
   assign done_pin.oe = done_oe_reg;
   assign cfg_done = cfg_done_reg;
   assign suspend_active = susp_reg;

   // ****************************************************************
   // Crossings into the test clock domain
   // ****************************************************************
   logic trst_s1_reg;
   logic trst_s2_reg;
   logic tdone_s1_reg;
   logic tdone_s2_reg;
   logic tsusp_s1_reg;
   logic tsusp_s2_reg;

   // Only the system reset restarts the controller; the reset pin does not.
   always_ff @(posedge tck) begin
      trst_s1_reg <= rst;
      trst_s2_reg <= trst_s1_reg;
      tdone_s1_reg <= cfg_done_reg;
      tdone_s2_reg <= tdone_s1_reg;
      tsusp_s1_reg <= susp_reg;
      tsusp_s2_reg <= tsusp_s1_reg;
   end

   wire tap_rst = trst_s2_reg;

   // ****************************************************************
   // Test access port controller
   // ****************************************************************
   function automatic cfgjt_pkg::cfgjt_tap_t tap_step(
      input cfgjt_pkg::cfgjt_tap_t s,
      input logic m
   );
      case (s)
         cfgjt_pkg::TAP_RESET:
            tap_step = m ? cfgjt_pkg::TAP_RESET : cfgjt_pkg::TAP_IDLE;
         cfgjt_pkg::TAP_IDLE:
            tap_step = m ? cfgjt_pkg::TAP_SEL_DR : cfgjt_pkg::TAP_IDLE;
         cfgjt_pkg::TAP_SEL_DR:
            tap_step = m ? cfgjt_pkg::TAP_SEL_IR : cfgjt_pkg::TAP_CAP_DR;
         cfgjt_pkg::TAP_CAP_DR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT1_DR : cfgjt_pkg::TAP_SHIFT_DR;
         cfgjt_pkg::TAP_SHIFT_DR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT1_DR : cfgjt_pkg::TAP_SHIFT_DR;
         cfgjt_pkg::TAP_EXIT1_DR:
            tap_step = m ? cfgjt_pkg::TAP_UPD_DR : cfgjt_pkg::TAP_PAUSE_DR;
         cfgjt_pkg::TAP_PAUSE_DR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT2_DR : cfgjt_pkg::TAP_PAUSE_DR;
         cfgjt_pkg::TAP_EXIT2_DR:
            tap_step = m ? cfgjt_pkg::TAP_UPD_DR : cfgjt_pkg::TAP_SHIFT_DR;
         cfgjt_pkg::TAP_UPD_DR:
            tap_step = m ? cfgjt_pkg::TAP_SEL_DR : cfgjt_pkg::TAP_IDLE;
         cfgjt_pkg::TAP_SEL_IR:
            tap_step = m ? cfgjt_pkg::TAP_RESET : cfgjt_pkg::TAP_CAP_IR;
         cfgjt_pkg::TAP_CAP_IR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT1_IR : cfgjt_pkg::TAP_SHIFT_IR;
         cfgjt_pkg::TAP_SHIFT_IR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT1_IR : cfgjt_pkg::TAP_SHIFT_IR;
         cfgjt_pkg::TAP_EXIT1_IR:
            tap_step = m ? cfgjt_pkg::TAP_UPD_IR : cfgjt_pkg::TAP_PAUSE_IR;
         cfgjt_pkg::TAP_PAUSE_IR:
            tap_step = m ? cfgjt_pkg::TAP_EXIT2_IR : cfgjt_pkg::TAP_PAUSE_IR;
         cfgjt_pkg::TAP_EXIT2_IR:
            tap_step = m ? cfgjt_pkg::TAP_UPD_IR : cfgjt_pkg::TAP_SHIFT_IR;
         cfgjt_pkg::TAP_UPD_IR:
            tap_step = m ? cfgjt_pkg::TAP_SEL_DR : cfgjt_pkg::TAP_IDLE;
         default:
            tap_step = cfgjt_pkg::TAP_RESET;
      endcase
   endfunction : tap_step

   cfgjt_pkg::cfgjt_tap_t tap_reg;
   cfgjt_pkg::cfgjt_tap_t tap_next;

   // Undriven inputs read as high, like the pull-ups on the pins.
   wire tms_eff = jtag_in.tms_en ? jtag_in.tms : 1'b1;
   wire tdi_eff = jtag_in.tdi_en ? jtag_in.tdi : 1'b1;

   assign tap_next = tap_step(tap_reg, tms_eff);

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         tap_reg <= cfgjt_pkg::TAP_RESET;
      end else begin
         tap_reg <= tap_next;
      end
   end

   // ****************************************************************
   // Instruction and data registers
   // ****************************************************************
   logic [IR_W-1:0] ir_shift_reg;
   logic [IR_W-1:0] ir_reg;
   logic [DR_W-1:0] dr_shift_reg;
   logic byp_reg;
   logic [DR_W-1:0] stat_word;

   wire in_cap_ir = (tap_reg == cfgjt_pkg::TAP_CAP_IR);
   wire in_shift_ir = (tap_reg == cfgjt_pkg::TAP_SHIFT_IR);
   wire in_upd_ir = (tap_reg == cfgjt_pkg::TAP_UPD_IR);
   wire in_cap_dr = (tap_reg == cfgjt_pkg::TAP_CAP_DR);
   wire in_shift_dr = (tap_reg == cfgjt_pkg::TAP_SHIFT_DR);
   wire in_reset = (tap_reg == cfgjt_pkg::TAP_RESET);
   wire sel_id = (ir_reg == IR_W'(`CFGJT_IR_IDCODE));
   wire sel_stat = (ir_reg == IR_W'(`CFGJT_IR_STATUS));
   wire sel_wide = sel_id || sel_stat;
   wire shifting = in_shift_ir || in_shift_dr;

   always_comb begin
      stat_word = '0;
      stat_word[`CFGJT_STAT_DONE_BIT] = tdone_s2_reg;
      stat_word[`CFGJT_STAT_SUSP_BIT] = tsusp_s2_reg;
   end

   always_ff @(posedge tck) begin
      if (tap_rst || in_reset) begin
         ir_reg <= IR_W'(`CFGJT_IR_IDCODE);
      end else if (in_upd_ir) begin
         ir_reg <= ir_shift_reg;
      end
   end

   // Each rising edge in a shift state moves the serial input into the chosen register.
   always_ff @(posedge tck) begin
      if (in_cap_ir) begin
         ir_shift_reg <= IR_W'(`CFGJT_IR_CAPTURE);
      end else if (in_shift_ir) begin
         ir_shift_reg <= {tdi_eff, ir_shift_reg[IR_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (in_cap_dr) begin
         dr_shift_reg <= sel_id ? ID_VALUE[DR_W-1:0] : stat_word;
         byp_reg <= 1'b0;
      end else if (in_shift_dr) begin
         if (sel_wide) begin
            dr_shift_reg <= {tdi_eff, dr_shift_reg[DR_W-1:1]};
         end else begin
            byp_reg <= tdi_eff;
         end
      end
   end

   // ****************************************************************
   // Serial output, launched on the falling edge
   // ****************************************************************
   logic tdo_reg;
   logic tdo_oe_reg;

   wire dr_bit = sel_wide ? dr_shift_reg[0] : byp_reg;
   wire tdo_bit = in_shift_ir ? ir_shift_reg[0] : dr_bit;

   always_ff @(negedge tck) begin
      if (tap_rst) begin
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else begin
         tdo_reg <= shifting ? tdo_bit : 1'b0;
         tdo_oe_reg <= shifting;
      end
   end

   assign jtag_out.tdo = tdo_reg;
   assign jtag_out.tdo_oe = tdo_oe_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   done_pin_level_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg_done_reg |-> (!done_oe_reg && cnt_at_end))
      else $error("done status high before configuration ended");

   done_rise_time_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(cfg_done_reg) |-> ($past(cnt_reg) == CNT_END))
      else $error("done status rose before the configuration count");

   prog_clear_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !prog_n |-> (!cfg_done_reg && done_oe_reg && cnt_reg == '0))
      else $error("reset pin did not clear configuration state");

   suspend_entry_a: assert property (
      @(posedge clk_sys) disable iff (rst || !prog_n)
      (susp_s2_reg && cfg_done_reg) |=> susp_reg)
      else $error("suspend request not honoured");

   tap_reset_walk_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      (!jtag_in.tms_en) [*5] |=> in_reset)
      else $error("undriven mode select did not reach reset");

   tap_idle_exit_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      (tap_reg == cfgjt_pkg::TAP_IDLE && tms_eff)
      |=> tap_reg == cfgjt_pkg::TAP_SEL_DR)
      else $error("controller did not follow mode select");

   tap_keep_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      (!prog_n && in_shift_dr && !tms_eff) |=> in_shift_dr)
      else $error("reset pin disturbed the test controller");

   ir_shift_in_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      in_shift_ir |=> ir_shift_reg[IR_W-1] == $past(tdi_eff))
      else $error("instruction shift lost the serial input");

   byp_pullup_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      (in_shift_dr && !sel_wide && !jtag_in.tdi_en) |=> byp_reg)
      else $error("undriven serial input did not shift a one");

   tdo_enable_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      $past(tap_reg) == tap_reg |-> tdo_oe_reg == shifting)
      else $error("serial output enable outside shift");

   tdo_value_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      (tdo_oe_reg && $past(tap_reg) == tap_reg) |-> tdo_reg == tdo_bit)
      else $error("serial output not launched on the falling edge");

   prog_release_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !prog_s2_reg |=> (cnt_reg == '0 && !cfg_done_reg))
      else $error("configuration left reset before the pin release");

   suspend_gate_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !cfg_done_reg |=> !susp_reg)
      else $error("suspend entered before configuration");

   tdo_idle_a: assert property (
      @(posedge tck) disable iff (tap_rst)
      !tdo_oe_reg |-> !jtag_out.tdo)
      else $error("serial output not parked while undriven");

endmodule : cfgjt_ctrl

// ===== hw/cfgjt_defs.svh
`ifndef CFGJT_DEFS_SVH
`define CFGJT_DEFS_SVH

// ****************************************************************
// System clock and configuration timing
// ****************************************************************
`define CFGJT_CLK_MHZ 10
`define CFGJT_CFG_TIME_NS 2000
`define CFGJT_CFG_CYCLES \
   ((`CFGJT_CFG_TIME_NS * `CFGJT_CLK_MHZ + 999) / 1000)

// ****************************************************************
// Test port register widths and instruction codes
// ****************************************************************
`define CFGJT_IR_W 6
`define CFGJT_DR_W 32
`define CFGJT_IR_CAPTURE 6'h01
`define CFGJT_IR_BYPASS 6'h3F
`define CFGJT_IR_IDCODE 6'h09
`define CFGJT_IR_STATUS 6'h05

// ****************************************************************
// Status word field positions
// ****************************************************************
`define CFGJT_STAT_DONE_BIT 0
`define CFGJT_STAT_SUSP_BIT 1

`endif

// ===== hw/cfgjt_pkg.sv
package cfgjt_pkg;

   // ****************************************************************
   // Test access port controller states
   // ****************************************************************
   typedef enum logic [3:0] {
      TAP_RESET,
      TAP_IDLE,
      TAP_SEL_DR,
      TAP_CAP_DR,
      TAP_SHIFT_DR,
      TAP_EXIT1_DR,
      TAP_PAUSE_DR,
      TAP_EXIT2_DR,
      TAP_UPD_DR,
      TAP_SEL_IR,
      TAP_CAP_IR,
      TAP_SHIFT_IR,
      TAP_EXIT1_IR,
      TAP_PAUSE_IR,
      TAP_EXIT2_IR,
      TAP_UPD_IR
   } cfgjt_tap_t;

   // ****************************************************************
   // Pin groups
   // ****************************************************************
   typedef struct packed {
      logic tms;
      logic tms_en;
      logic tdi;
      logic tdi_en;
   } cfgjt_jtag_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } cfgjt_jtag_out_t;

   typedef struct packed {
      logic o;
      logic oe;
   } cfgjt_done_pin_t;

endpackage : cfgjt_pkg

// ===== verif/cfgjt_host.sv
`timescale 1ns/1ps
module cfgjt_host (
   // Test clock and pins toward the device
   output logic tck,
   output cfgjt_pkg::cfgjt_jtag_in_t jtag_in,
   // Serial output from the device
   input wire cfgjt_pkg::cfgjt_jtag_out_t jtag_out
);
   // ****************************************************************
   // External test host
   // ****************************************************************
   logic tdo_rise;
   logic oe_rise;
   logic oe_all;
   logic steady;

   initial begin
      tck = 1'b0;
      jtag_in = '0;
      steady = 1'b1;
   end

   // A released pin toggles every clock so a stale value never passes.
   task automatic tick(input logic tms, input logic tdi,
         input logic [1:0] drv);
      #1;
      jtag_in.tms = drv[1] ? tms : ~jtag_in.tms;
      jtag_in.tms_en = drv[1];
      jtag_in.tdi = drv[0] ? tdi : ~jtag_in.tdi;
      jtag_in.tdi_en = drv[0];
      #23;
      tdo_rise = jtag_out.tdo;
      oe_rise = jtag_out.tdo_oe;
      tck = 1'b1;
      #1;
      steady = steady & (jtag_out.tdo === tdo_rise);
      #23;
      tck = 1'b0;
   endtask : tick

   // Walks from idle through one shift and back to idle, LSB first.
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
         input logic dtdi, output logic [31:0] dout);
      dout = '0;
      oe_all = 1'b1;
      steady = 1'b1;
      tick(1'b1, 1'b1, 2'b11);
      if (ir) tick(1'b1, 1'b1, 2'b11);
      tick(1'b0, 1'b1, 2'b11);
      tick(1'b0, 1'b1, 2'b11);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], {1'b1, dtdi});
         dout[i] = tdo_rise;
         oe_all = oe_all & oe_rise;
      end
      tick(1'b1, 1'b1, 2'b11);
      tick(1'b0, 1'b1, 2'b11);
   endtask : scan
endmodule : cfgjt_host

// ===== verif/test_config_control_and_jtag_pins.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      errors++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module test_config_control_and_jtag_pins;
   // ****************************************************************
   // Stimulus and checks
   // ****************************************************************
   localparam int CFGC = 12;
   // Arbitrary identification value.
   localparam logic [31:0] IDV = 32'h5E1D_00C3;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic prog_n = 1'b1;
   logic susp_pin = 1'b0;
   logic done_i;
   logic cfg_done;
   logic suspend_active;
   logic tck;
   cfgjt_pkg::cfgjt_done_pin_t done_pin;
   cfgjt_pkg::cfgjt_jtag_in_t jtag_in;
   cfgjt_pkg::cfgjt_jtag_out_t jtag_out;
   logic [31:0] din;
   logic [31:0] dout;
   int errors = 0;
   int samples_checked = 0;

   always #50 clk_sys = ~clk_sys;
   // The done wire has a pull-up and the device only pulls it low.
   assign done_i = done_pin.oe ? 1'b0 : 1'b1;

   cfgjt_ctrl #(.CFG_CYCLES(CFGC), .ID_VALUE(IDV)) dut (.clk_sys(clk_sys),
      .rst(rst), .prog_n(prog_n), .susp_pin(susp_pin), .done_i(done_i),
      .done_pin(done_pin), .cfg_done(cfg_done),
      .suspend_active(suspend_active), .tck(tck), .jtag_in(jtag_in),
      .jtag_out(jtag_out));
   cfgjt_host host (.tck(tck), .jtag_in(jtag_in), .jtag_out(jtag_out));

   // Bypass reference: one captured zero, then the input delayed a bit.
   function automatic logic [31:0] byp(input logic [15:0] d);
      logic q[$];
      logic [31:0] r;
      q = {1'b0};
      r = '0;
      for (int i = 0; i < 16; i++) begin
         q.push_back(d[i]);
         r[i] = q.pop_front();
      end
      return r;
   endfunction : byp

   task automatic cfg_check(input int lag);
      int k;
      k = 0;
      while (done_pin.oe === 1'b1 && k < 200) begin
         @(posedge clk_sys);
         #5;
         k++;
      end
      `CHK("cfg edges", CFGC + lag, k)
      `CHK("cfg_done early", 1'b0, cfg_done)
      repeat (3) @(posedge clk_sys);
      #5;
      `CHK("cfg_done", 1'b1, cfg_done)
      `CHK("done level", 1'b0, done_pin.o)
   endtask : cfg_check

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #100000;
      errors++;
      give_verdict();
   end

   initial begin
      void'($urandom(32'h93B9));
      din = $urandom;
      fork
         repeat (4) @(posedge clk_sys);
         repeat (6) host.tick(1'b1, 1'b1, 2'b11);
      join
      @(posedge clk_sys);
      #5;
      `CHK("oe in reset", 1'b1, done_pin.oe)
      `CHK("done in reset", 1'b0, cfg_done)
      `CHK("susp in reset", 1'b0, suspend_active)
      rst = 1'b0;
      cfg_check(0);
      repeat (2) host.tick(1'b1, 1'b1, 2'b11);
      host.tick(1'b0, 1'b1, 2'b11);
      host.scan(1'b0, 32, din, 1'b1, dout);
      `CHK("idcode", IDV, dout)
      `CHK("oe shift", 1'b1, host.oe_all)
      `CHK("tdo on fall", 1'b1, host.steady)
      host.tick(1'b0, 1'b1, 2'b11);
      `CHK("oe idle", 1'b0, host.oe_rise)
      host.scan(1'b1, 6, 32'h0000003F, 1'b1, dout);
      `CHK("ir capture", 6'h01, dout[5:0])
      din = $urandom;
      host.scan(1'b0, 16, din, 1'b1, dout);
      `CHK("bypass", byp(din[15:0]), dout)
      host.scan(1'b0, 16, din, 1'b0, dout);
      `CHK("tdi released", 32'h0000FFFE, dout)
      @(posedge clk_sys);
      #5;
      susp_pin = 1'b1;
      repeat (4) @(posedge clk_sys);
      #5;
      `CHK("suspend", 1'b1, suspend_active)
      host.scan(1'b1, 6, 32'h00000005, 1'b1, dout);
      repeat (4) host.tick(1'b0, 1'b1, 2'b11);
      host.scan(1'b0, 32, din, 1'b1, dout);
      `CHK("status", 32'h00000003, dout)
      @(posedge clk_sys);
      #5;
      susp_pin = 1'b0;
      prog_n = 1'b0;
      #1;
      `CHK("prog oe", 1'b1, done_pin.oe)
      `CHK("prog done", 1'b0, cfg_done)
      `CHK("prog susp", 1'b0, suspend_active)
      repeat (4) host.tick(1'b0, 1'b1, 2'b11);
      host.scan(1'b0, 32, din, 1'b1, dout);
      `CHK("tap kept", 32'h00000000, dout)
      @(posedge clk_sys);
      #5;
      prog_n = 1'b1;
      cfg_check(2);
      repeat (5) host.tick(1'b0, 1'b1, 2'b01);
      host.tick(1'b0, 1'b1, 2'b11);
      host.scan(1'b0, 32, din, 1'b1, dout);
      `CHK("tms released", IDV, dout)
      give_verdict();
   end
endmodule : test_config_control_and_jtag_pins
